// ==== hw/occ_pkg.sv ====
// package of constants for the oscillator control and status block
`default_nettype none
package occ_pkg;
  // register byte addresses
  localparam logic [11:0] OCC_CTRL_ADDR = 12'h000;
  localparam logic [11:0] OCC_UNLOCK_ADDR = 12'h004;
  localparam logic [11:0] OCC_IRQ_STAT_ADDR = 12'h008;
  localparam logic [11:0] OCC_IRQ_MASK_ADDR = 12'h00C;
  // unlock keys, written in order to the unlock register
  localparam logic [15:0] OCC_KEY1 = 16'h0046;
  localparam logic [15:0] OCC_KEY2 = 16'h0057;
  // field positions of the oscillator control register
  localparam int OCC_SW_REQ_BIT = 0;
  localparam int OCC_SECONDARY_OSCILLATOR_EN_BIT = 1;
  localparam int OCC_CF_BIT = 3;
  localparam int OCC_LOCK_BIT = 5;
  localparam int OCC_NEXT_SOURCE_SELECT_LSB = 8;
  localparam int OCC_COSC_LSB = 12;
  // reset values
  localparam logic [2:0] OCC_SRC_RESET = 3'h0;
  localparam logic [1:0] OCC_MASK_RESET = 2'h0;
  // clock source codes
  localparam logic [2:0] OCC_SRC_FRC = 3'h0;
  localparam logic [2:0] OCC_SRC_INTERNAL_RC_WITH_PLL = 3'h1;
  localparam logic [2:0] OCC_SRC_PRI = 3'h2;
  localparam logic [2:0] OCC_SRC_PRIPLL = 3'h3;
  localparam logic [2:0] OCC_SRC_SECONDARY_OSCILLATOR = 3'h4;
  localparam logic [2:0] OCC_SRC_FRCDIV = 3'h7;
  // switch latency in cycles
  localparam logic [3:0] OCC_SWITCH_CYCLES = 4'h8;
  // interrupt status bits
  localparam int OCC_IRQ_FAIL_BIT = 0;
  localparam int OCC_IRQ_SWDONE_BIT = 1;
  typedef enum logic [1:0] {OCC_IDLE, OCC_WAIT, OCC_DONE} occ_state_t;
endpackage
`default_nettype wire

// ==== hw/occ_top.sv ====
// oscillator control and status block with apb register access
// ****************************************************************
// ****************************************************************
`default_nettype none
module occ_top
  import occ_pkg::*;
#(
  parameter bit SMALL_PACKAGE = 1'b0
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic por_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pll_locked,
  input wire logic pll_timer_done,
  input wire logic failsafe_clock_monitor_fail,
  output logic secondary_osc_enable,
  output logic osc_fail_trap,
  output logic [2:0] current_source,
  output logic irq
);
  // ****************************************************************
  // bus decode
  // ****************************************************************
  logic acc;
  logic wr;
  logic rd;
  // a transfer completes on the access edge that sees pready high
  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;

  // the register answers in the access cycle with no wait states
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else
      pready <= psel & ~penable;
  end

  logic take;
  assign take = acc & pready;

  // ****************************************************************
  // unlock sequence
  // ****************************************************************
  logic [1:0] unlock_stage;
  // any other access in between breaks the sequence
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      unlock_stage <= 2'h0;
    else if (take && wr && paddr == OCC_UNLOCK_ADDR && pwdata[15:0] == OCC_KEY1)
      unlock_stage <= 2'h1;
    else if (take && wr && paddr == OCC_UNLOCK_ADDR && pwdata[15:0] == OCC_KEY2
             && unlock_stage == 2'h1)
      unlock_stage <= 2'h2;
    else if (take)
      unlock_stage <= 2'h0;
  end

  // the stage drops on the control write itself, so each write needs a fresh unlock
  logic ctrl_wr;
  assign ctrl_wr = take && wr && paddr == OCC_CTRL_ADDR && unlock_stage == 2'h2;

  // ****************************************************************
  // control register, power-on reset domain
  // ****************************************************************
  logic [2:0] next_source;
  logic sw_req;
  logic cf_flag;
  occ_state_t state;
  logic [3:0] sw_count;
  logic sw_done;
  assign sw_done = state == OCC_DONE;

  // the small package lacks the secondary oscillator, so that choice is remapped
  function automatic logic [2:0] map_src(input logic [2:0] s);
    if (SMALL_PACKAGE && s == OCC_SRC_SECONDARY_OSCILLATOR)
      map_src = OCC_SRC_FRCDIV;
    else
      map_src = s;
  endfunction

  // only por_n clears these; other reset causes keep them
  always_ff @(posedge pclk or negedge por_n)
  begin
    if (!por_n)
    begin
      next_source <= OCC_SRC_RESET;
      secondary_osc_enable <= 1'b0;
    end
    else if (ctrl_wr)
    begin
      next_source <= pwdata[OCC_NEXT_SOURCE_SELECT_LSB +: 3];
      secondary_osc_enable <= pwdata[OCC_SECONDARY_OSCILLATOR_EN_BIT];
    end
  end

  // request set by software, cleared by hardware on completion
  always_ff @(posedge pclk or negedge por_n)
  begin
    if (!por_n)
      sw_req <= 1'b0;
    else if (ctrl_wr && pwdata[OCC_SW_REQ_BIT])
      sw_req <= 1'b1;
    else if (sw_done)
      sw_req <= 1'b0;
  end

  // failure wins over a software clear in the same cycle
  always_ff @(posedge pclk or negedge por_n)
  begin
    if (!por_n)
      cf_flag <= 1'b0;
    else if (failsafe_clock_monitor_fail || (ctrl_wr && pwdata[OCC_CF_BIT]))
      cf_flag <= 1'b1;
    else if (ctrl_wr)
      cf_flag <= 1'b0;
  end

  // trap pulse for either real or emulated failure
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      osc_fail_trap <= 1'b0;
    else
      osc_fail_trap <= failsafe_clock_monitor_fail | (ctrl_wr & pwdata[OCC_CF_BIT]);
  end

  // ****************************************************************
  // switch sequencer
  // ****************************************************************
  // a fixed settle count stands in for the real source handover
  // it sits on power-on reset, so a warm reset cannot strand a switch half done
  always_ff @(posedge pclk or negedge por_n)
  begin
    if (!por_n)
    begin
      state <= OCC_IDLE;
      sw_count <= 4'h0;
      current_source <= OCC_SRC_RESET;
    end
    else
    begin
      case (state)
        OCC_IDLE:
          if (sw_req)
          begin
            state <= OCC_WAIT;
            sw_count <= 4'h0;
          end
        OCC_WAIT:
          if (sw_count == OCC_SWITCH_CYCLES - 4'h1)
          begin
            state <= OCC_DONE;
            current_source <= map_src(next_source);
          end
          else
            sw_count <= sw_count + 4'h1;
        OCC_DONE:
          state <= OCC_IDLE;
        default:
          state <= OCC_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // interrupts
  // ****************************************************************
  logic [1:0] irq_stat;
  logic [1:0] irq_mask;
  logic stat_rd;
  assign stat_rd = take && rd && paddr == OCC_IRQ_STAT_ADDR;

  // events win over the read-clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_stat <= 2'h0;
    else
    begin
      irq_stat[OCC_IRQ_FAIL_BIT] <= (irq_stat[OCC_IRQ_FAIL_BIT] & ~stat_rd)
        | failsafe_clock_monitor_fail | (ctrl_wr & pwdata[OCC_CF_BIT]);
      irq_stat[OCC_IRQ_SWDONE_BIT] <= (irq_stat[OCC_IRQ_SWDONE_BIT] & ~stat_rd) | sw_done;
    end
  end

  // mask bits gate the sticky status onto the interrupt line
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_mask <= OCC_MASK_RESET;
    else if (take && wr && paddr == OCC_IRQ_MASK_ADDR)
      irq_mask <= pwdata[1:0];
  end

  // level output, one cycle behind the status so it leaves a flip-flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(irq_stat & irq_mask);
  end

  // ****************************************************************
  // read data
  // ****************************************************************
  // live view of the control register; unused positions stay zero
  logic [15:0] ctrl_view;
  always_comb
  begin
    ctrl_view = 16'h0000; // bits 4 and 2 stay zero
    ctrl_view[OCC_COSC_LSB +: 3] = current_source;
    ctrl_view[OCC_NEXT_SOURCE_SELECT_LSB +: 3] = next_source;
    ctrl_view[OCC_LOCK_BIT] = pll_locked | pll_timer_done;
    ctrl_view[OCC_CF_BIT] = cf_flag;
    ctrl_view[OCC_SECONDARY_OSCILLATOR_EN_BIT] = secondary_osc_enable;
    ctrl_view[OCC_SW_REQ_BIT] = sw_req;
  end

  // unmapped offsets answer with an error and read as zero
  logic map_hit;
  assign map_hit = paddr == OCC_CTRL_ADDR || paddr == OCC_UNLOCK_ADDR
    || paddr == OCC_IRQ_STAT_ADDR || paddr == OCC_IRQ_MASK_ADDR;

  // read data registered at setup so it is stable during access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (psel && !penable)
    begin
      pslverr <= ~map_hit;
      case (paddr)
        OCC_CTRL_ADDR: prdata <= {16'h0000, ctrl_view};
        OCC_IRQ_STAT_ADDR: prdata <= {30'h0, irq_stat};
        OCC_IRQ_MASK_ADDR: prdata <= {30'h0, irq_mask};
        default: prdata <= 32'h0000_0000;
      endcase
    end
    else
      pslverr <= 1'b0;
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  // read data is judged at the pins, so a broken read path shows up here too
  lock_view_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && paddr == OCC_CTRL_ADDR)
    |=> prdata[OCC_LOCK_BIT] == $past(pll_locked | pll_timer_done))
    else $error("lock bit mismatch");
  zero_bits_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && paddr == OCC_CTRL_ADDR)
    |=> prdata[4] == 1'b0 && prdata[2] == 1'b0 && prdata[31:16] == 16'h0000)
    else $error("reserved bit set");
  // failure flag: set by either cause, held until software writes zero
  fail_sets_a: assert property (@(posedge pclk) disable iff (!por_n)
    failsafe_clock_monitor_fail |=> cf_flag)
    else $error("failure flag not set");
  cf_hold_a: assert property (@(posedge pclk) disable iff (!por_n)
    (cf_flag && !ctrl_wr) |=> cf_flag)
    else $error("failure flag lost");
  cf_clear_a: assert property (@(posedge pclk) disable iff (!por_n)
    (ctrl_wr && !pwdata[OCC_CF_BIT] && !failsafe_clock_monitor_fail) |=> !cf_flag)
    else $error("failure flag not cleared");
  // the trap follows each failure cycle and nothing else
  emul_trap_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_wr && pwdata[OCC_CF_BIT]) |=> osc_fail_trap && cf_flag)
    else $error("emulated failure did not trap");
  fail_trap_a: assert property (@(posedge pclk) disable iff (!presetn)
    failsafe_clock_monitor_fail |=> osc_fail_trap)
    else $error("detected failure did not trap");
  trap_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
    osc_fail_trap |-> $past(failsafe_clock_monitor_fail || (ctrl_wr && pwdata[OCC_CF_BIT])))
    else $error("trap without a failure");
  // the secondary enable follows every accepted write
  secondary_oscillator_follow_a: assert property (@(posedge pclk) disable iff (!por_n)
    ctrl_wr |=> secondary_osc_enable == $past(pwdata[OCC_SECONDARY_OSCILLATOR_EN_BIT]))
    else $error("secondary enable wrong");
  // a request stays up until the sequencer finishes, which takes a fixed time
  req_hold_a: assert property (@(posedge pclk) disable iff (!por_n)
    (sw_req && !sw_done) |=> sw_req)
    else $error("switch request dropped early");
  switch_time_a: assert property (@(posedge pclk) disable iff (!por_n)
    $rose(sw_req) |-> ##9 sw_done)
    else $error("switch took the wrong time");
  switch_ends_a: assert property (@(posedge pclk) disable iff (!por_n)
    $rose(sw_req) |-> ##[1:12] !sw_req)
    else $error("switch never completed");
  // a control write without the unlock moves neither the source select nor the secondary enable
  locked_write_a: assert property (@(posedge pclk) disable iff (!por_n)
    (take && wr && paddr == OCC_CTRL_ADDR && unlock_stage != 2'h2)
    |=> $stable(next_source) && $stable(secondary_osc_enable))
    else $error("write taken without unlock");
  // a warm reset leaves the control register alone
  warm_reset_a: assert property (@(posedge pclk) disable iff (!por_n)
    (!presetn && !failsafe_clock_monitor_fail) |=> $stable(next_source) && $stable(secondary_osc_enable) && $stable(cf_flag))
    else $error("control register lost on warm reset");
  small_pkg_a: assert property (@(posedge pclk) disable iff (!por_n)
    SMALL_PACKAGE |-> current_source != OCC_SRC_SECONDARY_OSCILLATOR)
    else $error("secondary source on small package");
  // the failure status bit is sticky and an unmasked status bit raises the line
  stat_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
    (irq_stat[OCC_IRQ_FAIL_BIT] && !stat_rd) |=> irq_stat[OCC_IRQ_FAIL_BIT])
    else $error("failure status lost");
  irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    (irq_stat & irq_mask) != 2'h0 |=> irq)
    else $error("interrupt line low");
  // main scenarios
  switch_c: cover property (@(posedge pclk) disable iff (!por_n) sw_done);
  trap_c: cover property (@(posedge pclk) disable iff (!presetn) osc_fail_trap);
  unlock_c: cover property (@(posedge pclk) disable iff (!presetn) ctrl_wr);
  emul_c: cover property (@(posedge pclk) disable iff (!presetn)
    ctrl_wr && pwdata[OCC_CF_BIT]);
  warm_c: cover property (@(posedge pclk) disable iff (!por_n) !presetn);
endmodule
`default_nettype wire

// ==== bench/occ_tb.sv ====
// self-checking testbench for the oscillator control and status block
`default_nettype none
module testbench
  import occ_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // signals and designs
  // ****
  logic pclk = 1'h0, presetn = 1'h0, por_n = 1'h0, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, pll_locked = 1'h0, pll_timer_done = 1'h0, failsafe_clock_monitor_fail = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, sec_en, trap, irq, err;
  logic [2:0] cur, cur2;
  int num_errors = 0, tests_run = 0, trap_cnt = 0;
  // free-running 100 MHz clock
  always #5 pclk = ~pclk;
  // trap pulses are counted, so one event must give exactly one cycle
  always @(posedge pclk)
    if (trap === 1'h1)
      trap_cnt <= trap_cnt + 1;
  occ_top occ_top_inst (.pclk(pclk), .presetn(presetn), .por_n(por_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pll_locked(pll_locked),
    .pll_timer_done(pll_timer_done), .failsafe_clock_monitor_fail(failsafe_clock_monitor_fail), .secondary_osc_enable(sec_en),
    .osc_fail_trap(trap), .current_source(cur), .irq(irq));
  // small-package copy sees the same traffic; only its source mapping is judged
  occ_top #(.SMALL_PACKAGE(1'h1)) occ_top_small_inst (.pclk(pclk), .presetn(presetn),
    .por_n(por_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
    .pll_locked(pll_locked), .pll_timer_done(pll_timer_done), .failsafe_clock_monitor_fail(failsafe_clock_monitor_fail),
    .secondary_osc_enable(), .osc_fail_trap(), .current_source(cur2),
    .irq());
  // ****
  // bus and check tasks
  // ****
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
    begin
      $display("STATUS OK");
    end
    else
    begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer; the wait for pready is bounded
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'h1 && n < 16);
    if (pready !== 1'h1)
    begin
      num_errors++;
      give_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic rd_reg(input logic [11:0] a);
    apb(1'h0, a, 32'h0);
  endtask
  // both keys, then the control write straight after them
  task automatic wr_ctrl(input logic [15:0] v);
    apb(1'h1, OCC_UNLOCK_ADDR, {16'h0, OCC_KEY1});
    apb(1'h1, OCC_UNLOCK_ADDR, {16'h0, OCC_KEY2});
    apb(1'h1, OCC_CTRL_ADDR, {16'h0, v});
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_reset_map();
    rd_reg(OCC_CTRL_ADDR);
    chk(rd, 32'h0);
    rd_reg(OCC_IRQ_MASK_ADDR);
    chk(rd, 32'h0);
    rd_reg(12'h010);
    chk({rd[30:0], err}, 32'h1);
  endtask
  task automatic t_lock();
    pll_locked <= 1'h1;
    rd_reg(OCC_CTRL_ADDR);
    chk(rd & 32'h20, 32'h20);
    pll_locked <= 1'h0;
    pll_timer_done <= 1'h1;
    rd_reg(OCC_CTRL_ADDR);
    chk(rd & 32'h20, 32'h20);
    pll_timer_done <= 1'h0;
    rd_reg(OCC_CTRL_ADDR);
    chk(rd & 32'h20, 32'h0);
  endtask
  task automatic t_unlock();
    apb(1'h1, OCC_CTRL_ADDR, 32'h0000_020B);
    rd_reg(OCC_CTRL_ADDR);
    chk(rd, 32'h0);
    wr_ctrl(16'h0016);
    rd_reg(OCC_CTRL_ADDR);
    chk(rd, 32'h2);
    chk(32'(sec_en), 32'h1);
    apb(1'h1, OCC_UNLOCK_ADDR, {16'h0, OCC_KEY1});
    apb(1'h1, OCC_UNLOCK_ADDR, {16'h0, OCC_KEY2});
    rd_reg(OCC_IRQ_STAT_ADDR);
    apb(1'h1, OCC_CTRL_ADDR, 32'h0);
    chk(32'(sec_en), 32'h1);
    wr_ctrl(16'h0000);
    chk(32'(sec_en), 32'h0);
    wr_ctrl(16'h0002);
  endtask
  task automatic t_fail();
    int c0;
    c0 = trap_cnt;
    failsafe_clock_monitor_fail <= 1'h1;
    @(posedge pclk);
    failsafe_clock_monitor_fail <= 1'h0;
    repeat (3) @(posedge pclk);
    chk(trap_cnt, c0 + 1);
    chk(32'(irq), 32'h0);
    rd_reg(OCC_CTRL_ADDR);
    chk(rd & 32'h8, 32'h8);
    apb(1'h1, OCC_IRQ_MASK_ADDR, 32'h3);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h1);
    rd_reg(OCC_IRQ_STAT_ADDR);
    chk(rd & 32'h1, 32'h1);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h0);
    wr_ctrl(16'h0002);
    rd_reg(OCC_CTRL_ADDR);
    chk(rd & 32'h8, 32'h0);
    wr_ctrl(16'h000A);
    rd_reg(OCC_CTRL_ADDR);
    chk(rd & 32'h8, 32'h8);
    chk(trap_cnt, c0 + 2);
    wr_ctrl(16'h0002);
    rd_reg(OCC_IRQ_STAT_ADDR);
  endtask
  task automatic t_switch();
    // pll modes are always left through plain rc, never directly
    logic [2:0] seq [6] = '{OCC_SRC_PRI, OCC_SRC_SECONDARY_OSCILLATOR, OCC_SRC_INTERNAL_RC_WITH_PLL, OCC_SRC_FRC,
      OCC_SRC_PRIPLL, OCC_SRC_FRC};
    int n;
    for (int i = 0; i < 6; i++)
    begin
      wr_ctrl({5'h0, seq[i], 8'h03});
      n = 0;
      do
      begin
        rd_reg(OCC_CTRL_ADDR);
        n++;
      end
      while (rd[0] !== 1'h0 && n < 20);
      if (rd[0] !== 1'h0)
      begin
        num_errors++;
        give_verdict();
      end
      chk(rd & 32'h7001, {17'h0, seq[i], 12'h0});
      chk(32'(cur), 32'(seq[i]));
      chk(32'(cur2), 32'(seq[i] == OCC_SRC_SECONDARY_OSCILLATOR ? OCC_SRC_FRCDIV : seq[i]));
      rd_reg(OCC_IRQ_STAT_ADDR);
      chk(rd & 32'h2, 32'h2);
    end
  endtask
  task automatic t_resets();
    wr_ctrl(16'h020A);
    presetn <= 1'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    rd_reg(OCC_CTRL_ADDR);
    chk(rd, 32'h20A);
    chk(32'(sec_en), 32'h1);
    rd_reg(OCC_IRQ_MASK_ADDR);
    chk(rd, 32'h0);
    presetn <= 1'h0;
    por_n <= 1'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    por_n <= 1'h1;
    @(posedge pclk);
    rd_reg(OCC_CTRL_ADDR);
    chk(rd, 32'h0);
  endtask
  // ****
  // main sequence
  // ****
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    por_n <= 1'h1;
    @(posedge pclk);
    t_reset_map();
    t_lock();
    t_unlock();
    t_fail();
    t_switch();
    t_resets();
    give_verdict();
  end
endmodule
`default_nettype wire
